/* spdcd_pkg.sv */
`default_nettype none
package spdcd_pkg;

  localparam int unsigned SYNC_STAGES     = 3;
  localparam int unsigned BYTE_BITS       = 8;
  localparam int unsigned CNT_W           = 5;
  localparam logic [4:0]  CNT_POS_FIRST   = 5'h04;
  localparam logic [4:0]  CNT_CTRL_END    = 5'h08;
  localparam logic [4:0]  CNT_ADDR_END    = 5'h10;
  localparam logic [4:0]  CNT_PACKET_END  = 5'h18;
  localparam int unsigned CTRL_BCAST_BIT  = 7;
  localparam int unsigned CTRL_RNW_BIT    = 6;
  localparam int unsigned CTRL_ZERO_HI    = 5;
  localparam int unsigned CTRL_ZERO_LO    = 4;
  localparam logic [7:0]  REG_COUNT       = 8'h05;
  localparam logic [7:0]  UNMAPPED_DATA   = 8'h00;
  localparam int unsigned FIFO_WIDTH      = 16;
  localparam int unsigned FIFO_DEPTH      = 8;
  localparam logic        SCLK_RST        = 1'b0;
  localparam logic        SELECT_N_RST    = 1'b1;
  localparam logic        DIN_RST         = 1'b0;

  typedef enum logic [1:0] {
    SPDCD_CTRL = 2'b00,
    SPDCD_ADDR = 2'b01,
    SPDCD_DATA = 2'b10,
    SPDCD_DONE = 2'b11
  } spdcd_state_e;

endpackage : spdcd_pkg
`default_nettype wire

/* spdcd_fifo.sv */
`timescale 1ns/100ps
`default_nettype none
module spdcd_fifo #(
  parameter int unsigned WIDTH = 16,
  parameter int unsigned DEPTH = 8
) (
  input  wire logic             clk_in,
  input  wire logic             rst_n_in,
  input  wire logic             ce_in,
  input  wire logic             in_valid_in,
  output logic                  in_ready_out,
  input  wire logic [WIDTH-1:0] in_data_in,
  output logic                  out_valid_out,
  input  wire logic             out_ready_in,
  output logic [WIDTH-1:0]      out_data_out
);
  localparam int unsigned AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wptr_reg;
  logic [AW-1:0]    rptr_reg;
  logic [AW:0]      count_reg;
  logic             out_valid_reg;
  logic [WIDTH-1:0] out_data_reg;

  wire  full  = (count_reg == (AW+1)'(DEPTH));
  wire  empty = (count_reg == '0);
  wire  push  = in_valid_in && !full;
  // Output register refills whenever it is empty or being drained
  wire  pop   = !empty && (!out_valid_reg || out_ready_in);

  assign in_ready_out  = !full;
  assign out_valid_out = out_valid_reg;
  assign out_data_out  = out_data_reg;

  always_ff @(posedge clk_in) begin
    if (ce_in && push) begin
      mem_reg[wptr_reg] <= in_data_in;
    end
  end

  always_ff @(posedge clk_in) begin
    if (!rst_n_in) begin
      wptr_reg      <= '0;
      rptr_reg      <= '0;
      count_reg     <= '0;
      out_valid_reg <= 1'b0;
      out_data_reg  <= '0;
    end else if (ce_in) begin
      if (push) begin
        wptr_reg <= (wptr_reg == AW'(DEPTH-1)) ? '0 : wptr_reg + 1'b1;
      end
      if (pop) begin
        rptr_reg     <= (rptr_reg == AW'(DEPTH-1)) ? '0 : rptr_reg + 1'b1;
        out_data_reg <= mem_reg[rptr_reg];
      end
      count_reg <= count_reg + (AW+1)'(push) - (AW+1)'(pop);
      if (pop) begin
        out_valid_reg <= 1'b1;
      end else if (out_ready_in) begin
        out_valid_reg <= 1'b0;
      end
    end
  end
endmodule : spdcd_fifo
`default_nettype wire

/* spdcd_decoder.sv */
// Function
// - Control byte: bit7 broadcast, bit6 read, bits5:4 zero, bits3..0 reversed chain position.
// - Reads ignore the broadcast flag; only one device is read per packet.
// - Addressed read shifts data out during byte 2; serial output idle otherwise.
// - Serial output stays undriven through every write packet.
// - Broadcast write updates the register on every device regardless of position.
// - Non-broadcast write updates only the device whose position field is zero.
// - Every input bit is forwarded unchanged, except the chain position bits.
// - Chain position field is decremented by one while forwarded.
// - Device receiving position zero is addressed and acts as a single device.
// - Only broadcast write, addressed write and addressed read are supported.
// - Up to sixteen chained devices sharing select, clock and serial output lines.
// - Shifting only while select low; rising-edge sampling, MSB first, eight-bit bytes.
// - A write to an unmapped address changes nothing.
// - A read from an unmapped address returns zero.
// - A clock rise with select high resets the sequencer; next frame starts with control.
`timescale 1ns/100ps
`default_nettype none
module spdcd_decoder
  import spdcd_pkg::*;
(
  input  wire logic        CLOCK_IN,
  input  wire logic        RST_N_IN,
  input  wire logic        CLK_EN_IN,
  input  wire logic        SCLK_IN,
  input  wire logic        SELECT_N_IN,
  input  wire logic        SERIAL_IN,
  output logic             SERIAL_OUT,
  output logic             SERIAL_OE_OUT,
  output logic             SERIAL_PASS_OUT,
  output logic [7:0]       RD_ADDR_OUT,
  input  wire logic [7:0]  RD_DATA_IN,
  output logic             REG_WR_VALID_OUT,
  input  wire logic        REG_WR_READY_IN,
  output logic [7:0]       REG_WR_ADDR_OUT,
  output logic [7:0]       REG_WR_DATA_OUT,
  output logic             ADDRESSED_OUT,
  output logic             WR_DROP_OUT
);

  function automatic logic is_mapped(input logic [7:0] addr);
    is_mapped = (addr < REG_COUNT);
  endfunction : is_mapped

  // Index 0 = serial clock, 1 = select, 2 = serial data
  localparam logic [2:0] SYNC_RST = {DIN_RST, SELECT_N_RST, SCLK_RST};

  wire  [2:0] raw_in = {SERIAL_IN, SELECT_N_IN, SCLK_IN};
  logic [2:0] stable_reg;
  logic [2:0] stable_next;

  genvar gi;
  generate
    for (gi = 0; gi < 3; gi++) begin : g_sync
      logic [SYNC_STAGES-1:0] sh_reg;
      always_ff @(posedge CLOCK_IN) begin
        if (!RST_N_IN) begin
          sh_reg <= {SYNC_STAGES{SYNC_RST[gi]}};
        end else if (CLK_EN_IN) begin
          sh_reg <= {sh_reg[SYNC_STAGES-2:0], raw_in[gi]};
        end
      end
      // Stage 0 feeds only stage 1; a level counts once stages 1 and 2 agree
      assign stable_next[gi] = (sh_reg[1] == sh_reg[2]) ? sh_reg[2] : stable_reg[gi];
    end
  endgenerate

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      stable_reg <= SYNC_RST;
    end else if (CLK_EN_IN) begin
      stable_reg <= stable_next;
    end
  end

  wire sclk_rise = stable_next[0] && !stable_reg[0];
  wire sel_n     = stable_next[1];
  wire din       = stable_next[2];
  wire shift_ev  = sclk_rise && !sel_n;
  wire resync_ev = (sclk_rise && sel_n) || (sel_n && !stable_reg[1]);

  spdcd_state_e state_reg;
  spdcd_state_e state_next;
  logic [CNT_W-1:0] cnt_reg;
  logic [7:0]       ctrl_reg;
  logic [7:0]       addr_reg;
  logic [7:0]       shin_reg;
  logic [7:0]       shout_reg;
  logic             borrow_reg;
  logic             pos_zero_reg;
  logic             load_pend_reg;
  logic             oe_reg;
  logic             pass_reg;
  logic             wr_pend_reg;
  logic [15:0]      wr_word_reg;
  logic             drop_reg;

  wire  [CNT_W-1:0] cnt_inc   = cnt_reg + 1'b1;
  wire  [7:0]       shin_next = {shin_reg[6:0], din};
  wire              in_pos    = (state_reg == SPDCD_CTRL) && (cnt_reg >= CNT_POS_FIRST);
  // Field arrives LSB first, so a serial borrow chain subtracts one
  // Four-bit field wraps from zero to all ones, which bounds a chain at sixteen devices
  wire              pass_next = in_pos ? (din ^ borrow_reg) : din;

  always_comb begin
    state_next = state_reg;
    case (state_reg)
      SPDCD_CTRL: state_next = (cnt_inc == CNT_CTRL_END) ? SPDCD_ADDR : SPDCD_CTRL;
      SPDCD_ADDR: state_next = (cnt_inc == CNT_ADDR_END) ? SPDCD_DATA : SPDCD_ADDR;
      SPDCD_DATA: state_next = (cnt_inc == CNT_PACKET_END) ? SPDCD_DONE : SPDCD_DATA;
      SPDCD_DONE: state_next = SPDCD_DONE;
      default:    state_next = SPDCD_CTRL;
    endcase
  end

  wire ctrl_legal = !ctrl_reg[CTRL_ZERO_HI] && !ctrl_reg[CTRL_ZERO_LO];
  wire is_read    = ctrl_reg[CTRL_RNW_BIT];
  wire is_bcast   = ctrl_reg[CTRL_BCAST_BIT];
  wire read_sel   = ctrl_legal && is_read && pos_zero_reg;
  wire write_sel  = ctrl_legal && !is_read && (is_bcast || pos_zero_reg);
  wire addr_done  = shift_ev && (state_reg == SPDCD_ADDR) && (cnt_inc == CNT_ADDR_END);
  wire data_done  = shift_ev && (state_reg == SPDCD_DATA) && (cnt_inc == CNT_PACKET_END);
  wire commit     = data_done && write_sel && is_mapped(addr_reg);
  wire fifo_ready;
  wire wr_handshake = wr_pend_reg && fifo_ready;

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      state_reg    <= SPDCD_CTRL;
      cnt_reg      <= '0;
      ctrl_reg     <= 8'h00;
      addr_reg     <= 8'h00;
      shin_reg     <= 8'h00;
      borrow_reg   <= 1'b1;
      pos_zero_reg <= 1'b1;
    end else if (CLK_EN_IN) begin
      if (resync_ev) begin
        state_reg    <= SPDCD_CTRL;
        cnt_reg      <= '0;
        borrow_reg   <= 1'b1;
        pos_zero_reg <= 1'b1;
      end else if (shift_ev && state_reg != SPDCD_DONE) begin
        state_reg <= state_next;
        cnt_reg   <= cnt_inc;
        shin_reg  <= shin_next;
        if (in_pos) begin
          borrow_reg   <= borrow_reg && !din;
          pos_zero_reg <= pos_zero_reg && !din;
        end
        if (state_reg == SPDCD_CTRL && cnt_inc == CNT_CTRL_END) begin
          ctrl_reg <= shin_next;
        end
        if (addr_done) begin
          addr_reg <= shin_next;
        end
      end
    end
  end

  // Read path: address latched at end of byte 1, data sampled one clock later
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      load_pend_reg <= 1'b0;
      oe_reg        <= 1'b0;
      shout_reg     <= 8'h00;
      RD_ADDR_OUT   <= 8'h00;
    end else if (CLK_EN_IN) begin
      load_pend_reg <= addr_done && read_sel && !resync_ev;
      if (addr_done) begin
        RD_ADDR_OUT <= shin_next;
      end
      if (resync_ev || data_done) begin
        oe_reg <= 1'b0;
      end else if (load_pend_reg) begin
        oe_reg    <= 1'b1;
        shout_reg <= is_mapped(RD_ADDR_OUT) ? RD_DATA_IN : UNMAPPED_DATA;
      end else if (shift_ev && oe_reg) begin
        shout_reg <= {shout_reg[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      pass_reg      <= DIN_RST;
      SERIAL_OUT    <= 1'b0;
      SERIAL_OE_OUT <= 1'b0;
      ADDRESSED_OUT <= 1'b0;
    end else if (CLK_EN_IN) begin
      // Forwarding adds about four clocks of lag per device, hence slower clock on long chains
      pass_reg      <= pass_next;
      SERIAL_OUT    <= oe_reg ? shout_reg[7] : 1'b0;
      SERIAL_OE_OUT <= oe_reg;
      ADDRESSED_OUT <= (state_reg != SPDCD_CTRL) && pos_zero_reg;
    end
  end
  assign SERIAL_PASS_OUT = pass_reg;

  // A pending write blocks the next one; a commit meeting the handshake wins
  always_ff @(posedge CLOCK_IN) begin
    if (!RST_N_IN) begin
      wr_pend_reg <= 1'b0;
      wr_word_reg <= 16'h0000;
      drop_reg    <= 1'b0;
    end else if (CLK_EN_IN) begin
      if (commit && (!wr_pend_reg || wr_handshake)) begin
        wr_pend_reg <= 1'b1;
        wr_word_reg <= {addr_reg, shin_next};
      end else if (wr_handshake) begin
        wr_pend_reg <= 1'b0;
      end
      drop_reg <= commit && wr_pend_reg && !wr_handshake;
    end
  end
  assign WR_DROP_OUT = drop_reg;

  logic [15:0] fifo_data;

  spdcd_fifo #(
    .WIDTH (FIFO_WIDTH),
    .DEPTH (FIFO_DEPTH)
  ) u_fifo (
    .clk_in        (CLOCK_IN),
    .rst_n_in      (RST_N_IN),
    .ce_in         (CLK_EN_IN),
    .in_valid_in   (wr_pend_reg),
    .in_ready_out  (fifo_ready),
    .in_data_in    (wr_word_reg),
    .out_valid_out (REG_WR_VALID_OUT),
    .out_ready_in  (REG_WR_READY_IN),
    .out_data_out  (fifo_data)
  );

  assign REG_WR_ADDR_OUT = fifo_data[15:8];
  assign REG_WR_DATA_OUT = fifo_data[7:0];

endmodule : spdcd_decoder
`default_nettype wire

/* spdcd_decoder_assertions.sv */
`timescale 1ns/100ps
`default_nettype none
module spdcd_checker
  import spdcd_pkg::*;
(
  input wire logic       CLOCK_IN,
  input wire logic       RST_N_IN,
  input wire logic       SELECT_N_IN,
  input wire logic       SERIAL_IN,
  input wire logic       SERIAL_OUT,
  input wire logic       SERIAL_OE_OUT,
  input wire logic       SERIAL_PASS_OUT,
  input wire logic       REG_WR_VALID_OUT,
  input wire logic       REG_WR_READY_IN,
  input wire logic [7:0] REG_WR_ADDR_OUT,
  input wire logic [7:0] REG_WR_DATA_OUT,
  input wire logic       ADDRESSED_OUT,
  input wire logic       WR_DROP_OUT
);
  default clocking cb @(posedge CLOCK_IN); endclocking
  default disable iff (!RST_N_IN);
  // Eight cycles covers the select synchroniser plus the two-cycle release
  property p_oe_idle; SELECT_N_IN [*8] |-> !SERIAL_OE_OUT; endproperty
  a_oe_idle: assert property (p_oe_idle) else $error("read pin driven while idle");
  property p_out_low; !SERIAL_OE_OUT |-> !SERIAL_OUT; endproperty
  a_out_low: assert property (p_out_low) else $error("read data not low while undriven");
  property p_oe_who; $rose(SERIAL_OE_OUT) |-> ADDRESSED_OUT && !SELECT_N_IN; endproperty
  a_oe_who: assert property (p_oe_who) else $error("unaddressed device drives read pin");
  property p_oe_len; $rose(SERIAL_OE_OUT) |-> SERIAL_OE_OUT [*8]; endproperty
  a_oe_len: assert property (p_oe_len) else $error("read drive cut short");
  property p_wr_map; REG_WR_VALID_OUT |-> REG_WR_ADDR_OUT < REG_COUNT; endproperty
  a_wr_map: assert property (p_wr_map) else $error("write to unmapped address");
  property p_wr_hold;
    REG_WR_VALID_OUT && !REG_WR_READY_IN |=>
      REG_WR_VALID_OUT && $stable(REG_WR_ADDR_OUT) && $stable(REG_WR_DATA_OUT);
  endproperty
  a_wr_hold: assert property (p_wr_hold) else $error("write word changed before taken");
  property p_drop; WR_DROP_OUT |=> !WR_DROP_OUT; endproperty
  a_drop: assert property (p_drop) else $error("drop flag longer than one cycle");
  property p_pass; (SELECT_N_IN && $stable(SERIAL_IN)) [*8] |-> SERIAL_PASS_OUT == SERIAL_IN; endproperty
  a_pass: assert property (p_pass) else $error("pass output does not follow input");
endmodule : spdcd_checker
bind spdcd_decoder spdcd_checker u_chk (.CLOCK_IN, .RST_N_IN, .SELECT_N_IN, .SERIAL_IN, .SERIAL_OUT,
  .SERIAL_OE_OUT, .SERIAL_PASS_OUT, .REG_WR_VALID_OUT, .REG_WR_READY_IN, .REG_WR_ADDR_OUT,
  .REG_WR_DATA_OUT, .ADDRESSED_OUT, .WR_DROP_OUT);
`default_nettype wire

/* spdcd_spi_master.sv */
`timescale 1ns/100ps
`default_nettype none
module spdcd_spi_master (
  input  wire logic clk_in,
  input  wire logic miso_in,
  input  wire logic miso_oe_in,
  input  wire logic pass_in,
  output logic      sclk_out,
  output logic      sel_n_out,
  output logic      mosi_out
);
  logic [7:0]  rx_byte;
  logic [23:0] pass_bits;
  logic        drove;
  logic        wire_bit;
  // No pull on the read line, so an undriven pin reads as the inverse of the last bit
  assign wire_bit = miso_oe_in ? miso_in : ~rx_byte[0];
  initial begin
    sclk_out = 1'b0;
    sel_n_out = 1'b1;
    mosi_out = 1'b0;
    rx_byte = 8'h00;
    pass_bits = 24'h000000;
    drove = 1'b0;
  end
  task half;
    repeat (4) @(posedge clk_in);
  endtask : half
  task send(input logic [23:0] pkt, input int nbits);
    int i;
    sclk_out <= 1'b1;
    half;
    sclk_out <= 1'b0;
    half;
    sel_n_out <= 1'b0;
    drove = 1'b0;
    for (i = 23; i >= 24 - nbits; i--) begin
      mosi_out <= pkt[i];
      half;
      sclk_out <= 1'b1;
      if (i < 8) rx_byte <= {rx_byte[6:0], wire_bit};
      drove = drove | miso_oe_in;
      half;
      sclk_out <= 1'b0;
      pass_bits <= {pass_bits[22:0], pass_in};
    end
    half;
    sel_n_out <= 1'b1;
    mosi_out <= ~mosi_out;
    half;
  endtask : send
endmodule : spdcd_spi_master
`default_nettype wire

/* tb_spi_daisy_chain_packet_decoder.sv */
`timescale 1ns/100ps
`default_nettype none
module tb_spi_daisy_chain_packet_decoder
  import spdcd_pkg::*;
;
  typedef struct packed {logic [23:0] pkt; logic wr; logic rd; logic [7:0] exp;} spdcd_row_s;
  logic        clk, rst_n, en, sclk, sel_n, mosi, miso, oe, pass, wr_valid, wr_ready, addressed, drop;
  logic [7:0]  rd_addr, rd_data, wr_addr, wr_data;
  int          failures, comparisons, drops, k;
  logic [15:0] got[$];
  spdcd_row_s  rows[9] = '{'{24'h00015A, 1, 0, 8'h5A}, '{24'h88023C, 1, 0, 8'h3C}, '{24'h080177, 0, 0, 0},
    '{24'h000511, 0, 0, 0}, '{24'h400300, 0, 1, 8'hC0}, '{24'hC00400, 0, 1, 8'hC7}, '{24'h480300, 0, 0, 0},
    '{24'h400700, 0, 1, 8'h00}, '{24'h300122, 0, 0, 0}};
  spdcd_decoder u_dut (.CLOCK_IN(clk), .RST_N_IN(rst_n), .CLK_EN_IN(en), .SCLK_IN(sclk), .SELECT_N_IN(sel_n),
    .SERIAL_IN(mosi), .SERIAL_OUT(miso), .SERIAL_OE_OUT(oe), .SERIAL_PASS_OUT(pass), .RD_ADDR_OUT(rd_addr),
    .RD_DATA_IN(rd_data), .REG_WR_VALID_OUT(wr_valid), .REG_WR_READY_IN(wr_ready), .REG_WR_ADDR_OUT(wr_addr),
    .REG_WR_DATA_OUT(wr_data), .ADDRESSED_OUT(addressed), .WR_DROP_OUT(drop));
  spdcd_spi_master u_master (.clk_in(clk), .miso_in(miso), .miso_oe_in(oe), .pass_in(pass),
    .sclk_out(sclk), .sel_n_out(sel_n), .mosi_out(mosi));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // Nonzero content everywhere except address C3, so an unmapped read must really be forced to zero
  assign rd_data = 8'hC3 ^ rd_addr;
  always @(posedge clk) begin
    // A frozen block takes nothing, so the collector honours the enable too
    if (en === 1'b1 && wr_valid === 1'b1 && wr_ready === 1'b1) got.push_back({wr_addr, wr_data});
    if (drop === 1'b1) drops++;
  end
  task chk(input logic [31:0] g, input logic [31:0] e);
    comparisons++;
    if (g !== e) begin
      failures++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
    end
  endtask : chk
  function automatic logic [7:0] fwd(input logic [7:0] c);
    logic [3:0] p;
    p = {c[0], c[1], c[2], c[3]} - 4'h1;
    return {c[7:4], p[0], p[1], p[2], p[3]};
  endfunction : fwd
  task close_out;
    if (failures == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : close_out
  initial begin
    #2000000;
    failures++;
    close_out();
  end
  initial begin
    rst_n <= 1'b0;
    en <= 1'b1;
    wr_ready <= 1'b1;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (4) @(posedge clk);
    chk({wr_valid, oe, addressed, pass}, 0);
    foreach (rows[i]) begin
      got.delete();
      u_master.send(rows[i].pkt, 24);
      repeat (8) @(posedge clk);
      chk(u_master.pass_bits, {fwd(rows[i].pkt[23:16]), rows[i].pkt[15:0]});
      chk(got.size(), rows[i].wr);
      if (rows[i].wr) chk(got[0], {rows[i].pkt[15:8], rows[i].exp});
      chk(u_master.drove, rows[i].rd);
      if (rows[i].rd) chk(u_master.rx_byte, rows[i].exp);
    end
    got.delete();
    u_master.send(24'hFFFFFF, 5);
    u_master.send(24'h000244, 24);
    repeat (8) @(posedge clk);
    chk({16'(got.size()), got[0]}, {16'h0001, 16'h0244});
    wr_ready <= 1'b0;
    got.delete();
    drops = 0;
    for (k = 0; k < 11; k++) u_master.send({16'h8003, 8'(k)}, 24);
    repeat (8) @(posedge clk);
    chk({31'(drops), wr_valid}, {31'h1, 1'b1});
    wr_ready <= 1'b1;
    repeat (30) @(posedge clk);
    chk({16'(got.size()), got[0]}, {16'(FIFO_DEPTH + 2), 16'h0300});
    wr_ready <= 1'b0;
    u_master.send(24'h000111, 24);
    repeat (8) @(posedge clk);
    // With the enable low a ready consumer must not drain the waiting word
    got.delete();
    en <= 1'b0;
    wr_ready <= 1'b1;
    repeat (4) @(posedge clk);
    chk({16'(got.size()), 15'h0000, wr_valid}, {16'h0000, 15'h0000, 1'b1});
    en <= 1'b1;
    wr_ready <= 1'b0;
    repeat (2) @(posedge clk);
    chk({wr_valid, wr_addr, wr_data}, {1'b1, 16'h0111});
    rst_n <= 1'b0;
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    chk({wr_valid, oe, addressed}, 0);
    close_out();
  end
endmodule : tb_spi_daisy_chain_packet_decoder
`default_nettype wire
